/* isc_config_regs.v */
// Sensor configuration register bank with APB slave and the logic it steers
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "isc_regs.vh"

module isc_config_regs (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Black level path
  input  wire [13:0] measured_black_level,
  output reg  [13:0] adc_black_level,
  output reg         black_level_correction,
  output reg  [15:0] black_offset_trim,
  // Readout sequencing
  input  wire        pipeline_mode,
  input  wire        frame_start,
  input  wire        row_done,
  output reg         dummy_row_active,
  // Pixel position
  input  wire        line_start,
  input  wire        pix_valid,
  output reg  [1:0]  pix_color,
  // Shutter
  input  wire        shutter_request,
  output reg         shutter_start,
  output reg         shutter_active,
  // PLL clock output
  output reg         pll1_clkout_enable,
  // Test pin sources from other domains
  input  wire        pll1_lock,
  input  wire        pll2_lock,
  input  wire        pixel_clock,
  input  wire        frame_irq_request,
  input  wire        exposure_irq_request,
  input  wire        global_shutter_start,
  input  wire        exposure_control,
  output reg         digital_test_pin
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [1:0] bayer_color;
    input x_odd;
    input y_odd;
    begin
      case ({y_odd, x_odd})
        2'h0: bayer_color = `ISC_COL_BLUE;
        2'h1: bayer_color = `ISC_COL_GREEN_B;
        2'h2: bayer_color = `ISC_COL_GREEN_R;
        default: bayer_color = `ISC_COL_RED;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg  [15:0] black_offset_fine;
  reg         black_correction_bypass;
  reg  [13:0] bypass_black_level;
  reg  [3:0]  dummy_row_count;
  reg         pll_clkout_gate;
  reg  [4:0]  test_pin_select;
  reg  [13:0] shutter_timing_length;
  reg  [13:0] capture_delay;
  wire [6:0]  idx = paddr[8:2];
  wire        wr_en = psel & penable & pready & pwrite & pstrb[0];
  wire [7:0]  wb = pwdata[7:0];
  reg  [7:0]  next_rdata;
  reg         next_err;
  wire [7:0]  status;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  always @* begin
    next_err = 1'b0;
    case (idx)
      `ISC_IDX_OFFS_LO:  next_rdata = black_offset_fine[7:0]; // R9
      `ISC_IDX_OFFS_HI:  next_rdata = black_offset_fine[15:8];
      `ISC_IDX_BYPASS:   next_rdata = {7'h00, black_correction_bypass};
      `ISC_IDX_BLVL_LO:  next_rdata = bypass_black_level[7:0]; // R9
      `ISC_IDX_BLVL_HI:  next_rdata = {2'h0, bypass_black_level[13:8]};
      `ISC_IDX_DUMMY:    next_rdata = {4'h0, dummy_row_count};
      `ISC_IDX_CLKGATE:  next_rdata = {7'h00, pll_clkout_gate};
      `ISC_IDX_TPSEL:    next_rdata = {3'h0, test_pin_select};
      `ISC_IDX_TGLEN_LO: next_rdata = shutter_timing_length[7:0];
      `ISC_IDX_TGLEN_HI: next_rdata = {2'h0, shutter_timing_length[13:8]};
      `ISC_IDX_DELAY_LO: next_rdata = capture_delay[7:0];
      `ISC_IDX_DELAY_HI: next_rdata = {2'h0, capture_delay[13:8]};
      `ISC_IDX_STATUS:   next_rdata = status;
      default: begin
        next_rdata = 8'h00;
        next_err = 1'b1;
      end
    endcase
    if (|paddr[31:9] || |paddr[1:0]) begin
      next_rdata = 8'h00;
      next_err = 1'b1;
    end
  end

  // Zero wait states: answer is set up during the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr <= next_err;
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, next_rdata};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      black_offset_fine       <= `ISC_RST_OFFS;
      black_correction_bypass <= `ISC_RST_BIT;
      bypass_black_level      <= `ISC_RST_LVL14;
      dummy_row_count         <= `ISC_RST_DUMMY;
      pll_clkout_gate         <= `ISC_RST_BIT;
      test_pin_select         <= `ISC_RST_TPSEL;
      shutter_timing_length   <= `ISC_RST_LVL14;
      capture_delay           <= `ISC_RST_LVL14;
    end else if (wr_en && !next_err) begin
      case (idx)
        `ISC_IDX_OFFS_LO:  black_offset_fine[7:0] <= wb; // R9
        `ISC_IDX_OFFS_HI:  black_offset_fine[15:8] <= wb; // R9
        `ISC_IDX_BYPASS:   black_correction_bypass <= wb[0];
        `ISC_IDX_BLVL_LO:  bypass_black_level[7:0] <= wb; // R9
        `ISC_IDX_BLVL_HI:  bypass_black_level[13:8] <= wb[5:0]; // R9
        `ISC_IDX_DUMMY:    dummy_row_count <= wb[3:0];
        `ISC_IDX_CLKGATE:  pll_clkout_gate <= wb[0];
        `ISC_IDX_TPSEL:    test_pin_select <= wb[4:0];
        `ISC_IDX_TGLEN_LO: shutter_timing_length[7:0] <= wb; // R9
        `ISC_IDX_TGLEN_HI: shutter_timing_length[13:8] <= wb[5:0]; // R9
        `ISC_IDX_DELAY_LO: capture_delay[7:0] <= wb; // R9
        `ISC_IDX_DELAY_HI: capture_delay[13:8] <= wb[5:0]; // R9
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Black level selection
  // ----------------------------------------
  // The fine trim is only forwarded; choosing the gain-matched value is software's job
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_black_level        <= `ISC_RST_LVL14;
      black_level_correction <= ~`ISC_RST_BIT; // R2
      black_offset_trim      <= `ISC_RST_OFFS;
      pll1_clkout_enable     <= ~`ISC_RST_BIT; // R7
    end else begin
      black_level_correction <= ~black_correction_bypass; // R2
      if (black_correction_bypass) begin
        adc_black_level <= bypass_black_level; // R3
      end else begin
        adc_black_level <= measured_black_level; // R2
      end
      black_offset_trim  <= black_offset_fine;
      pll1_clkout_enable <= ~pll_clkout_gate; // R7
    end
  end

  // ----------------------------------------
  // Dummy rows in pipelined readout
  // ----------------------------------------
  reg [3:0] dummy_left;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dummy_left       <= 4'h0;
      dummy_row_active <= 1'b0;
    end else begin
      if (frame_start) begin
        dummy_left       <= pipeline_mode ? dummy_row_count : 4'h0; // R4
        dummy_row_active <= pipeline_mode && (dummy_row_count != 4'h0); // R4
      end else if (row_done && dummy_left != 4'h0) begin
        dummy_left       <= dummy_left - 4'h1; // R4
        dummy_row_active <= (dummy_left != 4'h1);
      end
    end
  end

  // ----------------------------------------
  // Pixel colour tracking
  // ----------------------------------------
  reg x_odd;
  reg y_odd;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_odd     <= 1'b0;
      y_odd     <= 1'b0;
      pix_color <= `ISC_COL_BLUE;
    end else begin
      if (frame_start) begin
        x_odd     <= 1'b0; // R8
        y_odd     <= 1'b0; // R8
        pix_color <= `ISC_COL_BLUE; // R8
      end else if (line_start) begin
        x_odd     <= 1'b0;
        y_odd     <= ~y_odd;
        pix_color <= bayer_color(1'b0, ~y_odd);
      end else if (pix_valid) begin
        x_odd     <= ~x_odd;
        pix_color <= bayer_color(~x_odd, y_odd);
      end
    end
  end

  // ----------------------------------------
  // Shutter delay and length
  // ----------------------------------------
  localparam SH_IDLE  = 2'h0;
  localparam SH_DELAY = 2'h1;
  localparam SH_OPEN  = 2'h2;

  reg [1:0]  sh_state;
  reg [13:0] sh_count;
  // A request while busy is dropped so one exposure cannot be cut short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_state       <= SH_IDLE;
      sh_count       <= 14'h0000;
      shutter_start  <= 1'b0;
      shutter_active <= 1'b0;
    end else begin
      shutter_start <= 1'b0;
      case (sh_state)
        SH_IDLE: begin
          if (shutter_request) begin
            if (capture_delay == 14'h0000) begin
              sh_state       <= SH_OPEN;
              sh_count       <= shutter_timing_length;
              shutter_start  <= 1'b1;
              shutter_active <= 1'b1;
            end else begin
              sh_state <= SH_DELAY;
              sh_count <= capture_delay - 14'h0001; // R6
            end
          end
        end
        SH_DELAY: begin
          if (sh_count == 14'h0000) begin
            sh_state       <= SH_OPEN; // R6
            sh_count       <= shutter_timing_length;
            shutter_start  <= 1'b1;
            shutter_active <= 1'b1;
          end else begin
            sh_count <= sh_count - 14'h0001; // R6
          end
        end
        SH_OPEN: begin
          if (sh_count == 14'h0000) begin
            sh_state       <= SH_IDLE;
            shutter_active <= 1'b0;
          end else begin
            sh_count <= sh_count - 14'h0001;
          end
        end
        default: begin
          sh_state       <= SH_IDLE;
          shutter_active <= 1'b0;
        end
      endcase
    end
  end

  assign status = {4'h0, black_level_correction, dummy_row_active,
                   shutter_active, sh_state == SH_DELAY};

  // ----------------------------------------
  // Test pin multiplexer
  // ----------------------------------------
  // Three-stage capture; a source is slow-viewed, pixel clock above pclk/2 aliases
  reg [6:0] tp_s1;
  reg [6:0] tp_s2;
  reg [6:0] tp_s3;
  reg [6:0] tp_val;
  wire [6:0] tp_raw = {exposure_control, global_shutter_start, exposure_irq_request,
                       frame_irq_request, pixel_clock, pll2_lock, pll1_lock};
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_s1  <= 7'h00;
      tp_s2  <= 7'h00;
      tp_s3  <= 7'h00;
      tp_val <= 7'h00;
    end else begin
      tp_s1 <= tp_raw;
      tp_s2 <= tp_s1;
      tp_s3 <= tp_s2;
      for (i = 0; i < 7; i = i + 1) begin
        if (tp_s2[i] == tp_s3[i]) begin
          tp_val[i] <= tp_s3[i];
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_test_pin <= 1'b0;
    end else begin
      case (test_pin_select)
        `ISC_TP_PLL1_LOCK:  digital_test_pin <= tp_val[0]; // R5
        `ISC_TP_PLL2_LOCK:  digital_test_pin <= tp_val[1]; // R5
        `ISC_TP_PIXCLK:     digital_test_pin <= tp_val[2]; // R5
        `ISC_TP_FRAME_IRQ:  digital_test_pin <= tp_val[3]; // R5
        `ISC_TP_EXP_IRQ:    digital_test_pin <= tp_val[4]; // R5
        `ISC_TP_GLOBAL_SHUTTER_START: digital_test_pin <= tp_val[5]; // R5
        `ISC_TP_EXP_CTRL:   digital_test_pin <= tp_val[6]; // R5
        default:            digital_test_pin <= 1'b0; // R5
      endcase
    end
  end

endmodule

/* isc_regs.vh */
// Register indices, field layouts and reset values of the sensor configuration bank
// Behaviour
// R1 - Host writes black offset fine 32920, 33083 or 33418 for gain x1, x2, x4
// R2 - Correction bypass bit 0 applies black-level correction, 1 skips it; resets 0
// R3 - With correction off the 14-bit programmed value is the converter black level
// R4 - Pipelined readout inserts dummy rows counted by a 4-bit field, reset zero
// R5 - 5-bit select routes one internal signal to the digital test pin
// R6 - Shutter start is delayed by the 14-bit capture delay field, reset zero
// R7 - Clock-output gate bit 1 stops the first PLL output, 0 passes it
// R8 - Colour readout starts at pixel (0,0), bottom left, blue filter
// R9 - Two-address fields keep low eight bits low, upper bits at next address
`ifndef ISC_REGS_VH
`define ISC_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ISC_IDX_OFFS_LO   7'h26
`define ISC_IDX_OFFS_HI   7'h27
`define ISC_IDX_BYPASS    7'h2a
`define ISC_IDX_BLVL_LO   7'h2b
`define ISC_IDX_BLVL_HI   7'h2c
`define ISC_IDX_DUMMY     7'h2e
`define ISC_IDX_CLKGATE   7'h31
`define ISC_IDX_TPSEL     7'h63
`define ISC_IDX_TGLEN_LO  7'h6e
`define ISC_IDX_TGLEN_HI  7'h6f
`define ISC_IDX_DELAY_LO  7'h72
`define ISC_IDX_DELAY_HI  7'h73
`define ISC_IDX_STATUS    7'h74

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ISC_RST_OFFS      16'h0000
`define ISC_RST_BIT       1'h0
`define ISC_RST_LVL14     14'h0000
`define ISC_RST_DUMMY     4'h0
`define ISC_RST_TPSEL     5'h00

// ----------------------------------------
// Test pin select codes
// ----------------------------------------
`define ISC_TP_NONE       5'h00
`define ISC_TP_PLL1_LOCK  5'h01
`define ISC_TP_PLL2_LOCK  5'h02
`define ISC_TP_PIXCLK     5'h05
`define ISC_TP_FRAME_IRQ  5'h06
`define ISC_TP_EXP_IRQ    5'h07
`define ISC_TP_GLOBAL_SHUTTER_START 5'h0c
`define ISC_TP_EXP_CTRL   5'h0e

// ----------------------------------------
// Bayer colour codes and status bits
// ----------------------------------------
`define ISC_COL_BLUE      2'h0
`define ISC_COL_GREEN_B   2'h1
`define ISC_COL_GREEN_R   2'h2
`define ISC_COL_RED       2'h3
`define ISC_ST_DELAYING   0
`define ISC_ST_SHUTTER    1
`define ISC_ST_DUMMY      2
`define ISC_ST_CORR_ON    3

`endif

/* isc_config_regs_chk.sv */
// Assertion checker for the sensor configuration register bank
`timescale 1ns/10ps
`include "isc_regs.vh"

module isc_regs_chk (
  // Clock, reset and APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  // Core side
  input wire        black_level_correction,
  input wire        pipeline_mode,
  input wire        frame_start,
  input wire        dummy_row_active,
  input wire [1:0]  pix_color,
  input wire        shutter_start,
  input wire        shutter_active,
  input wire        pll1_clkout_enable
);
  // ------------------------------
  // Shadow bits, compared once settled so output latency stays free
  // ------------------------------
  wire      wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  reg [1:0] sh;
  reg [1:0] sh_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh   <= 2'h0;
      sh_d <= 2'h0;
    end else begin
      if (wr && paddr[8:2] == `ISC_IDX_BYPASS) sh[0] <= pwdata[0];
      if (wr && paddr[8:2] == `ISC_IDX_CLKGATE) sh[1] <= pwdata[0];
      sh_d <= sh;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  AST_CORR_ON: assert property (sh[0] == sh_d[0] |-> black_level_correction == !sh[0])
    else $error("correction flag wrong");
  AST_CLKGATE: assert property (sh[1] == sh_d[1] |-> pll1_clkout_enable == !sh[1])
    else $error("pll output gate wrong");
  AST_SHUT_PULSE: assert property (shutter_start |-> shutter_active ##1 !shutter_start)
    else $error("shutter start pulse wrong");
  AST_FIRST_BLUE: assert property (frame_start |=> pix_color == `ISC_COL_BLUE)
    else $error("frame does not start on blue");
  AST_NO_DUMMY: assert property (frame_start && !pipeline_mode |=> !dummy_row_active)
    else $error("dummy rows outside pipeline mode");
endmodule

bind isc_config_regs isc_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .black_level_correction(black_level_correction),
  .pipeline_mode(pipeline_mode), .frame_start(frame_start),
  .dummy_row_active(dummy_row_active), .pix_color(pix_color), .shutter_start(shutter_start),
  .shutter_active(shutter_active), .pll1_clkout_enable(pll1_clkout_enable));

/* isc_host_model.sv */
// Host controller model that configures the bank over APB
`timescale 1ns/10ps

module isc_host_model (
  // Clock
  input  wire        pclk,
  // APB master
  output reg         psel = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite = 1'b0,
  output reg  [31:0] paddr = 32'h0,
  output reg  [31:0] pwdata = 32'h0,
  output reg  [3:0]  pstrb = 4'hf,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  // Fine offsets for analog gain x1, x2 and x4
  reg [15:0] gains [0:2];

  initial begin
    gains[0] = 16'h8098;
    gains[1] = 16'h813b;
    gains[2] = 16'h828a;
  end

  // ------------------------------
  // One transfer; held until pready, then one idle cycle
  // ------------------------------
  task xfer(input [31:0] a, input w, input [7:0] d, output [8:0] r);
    integer n;
    begin
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (!pready && n < 16) begin
        @(posedge pclk);
        n = n + 1;
      end
      r = pready ? {pslverr, prdata[7:0]} : 9'h1ff;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
endmodule

/* test_image_sensor_config_regs.sv */
// Self-checking testbench for the sensor configuration register bank
`timescale 1ns/10ps
`include "isc_regs.vh"

module test_image_sensor_config_regs;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr, corr, dummy, sh_go, sh_on, clk_en, tpin;
  wire [31:0] paddr, pwdata, prdata;
  wire [3:0]  pstrb;
  wire [13:0] adc;
  wire [15:0] trim;
  wire [1:0]  col;
  reg  [13:0] meas = 14'h1234;
  reg         pipe = 1'b0;
  reg  [4:0]  ev = 5'h00;
  reg  [6:0]  src = 7'h00;
  reg  [8:0]  r;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     i;
  integer     n;
  reg  [6:0]  ri [0:11];
  reg  [4:0]  codes [0:6];

  // Mapped fields in address order; test pin codes in source bit order
  initial begin
    ri[0]    = `ISC_IDX_OFFS_LO;
    ri[1]    = `ISC_IDX_OFFS_HI;
    ri[2]    = `ISC_IDX_BYPASS;
    ri[3]    = `ISC_IDX_BLVL_LO;
    ri[4]    = `ISC_IDX_BLVL_HI;
    ri[5]    = `ISC_IDX_DUMMY;
    ri[6]    = `ISC_IDX_CLKGATE;
    ri[7]    = `ISC_IDX_TPSEL;
    ri[8]    = `ISC_IDX_TGLEN_LO;
    ri[9]    = `ISC_IDX_TGLEN_HI;
    ri[10]   = `ISC_IDX_DELAY_LO;
    ri[11]   = `ISC_IDX_DELAY_HI;
    codes[0] = `ISC_TP_PLL1_LOCK;
    codes[1] = `ISC_TP_PLL2_LOCK;
    codes[2] = `ISC_TP_PIXCLK;
    codes[3] = `ISC_TP_FRAME_IRQ;
    codes[4] = `ISC_TP_EXP_IRQ;
    codes[5] = `ISC_TP_GLOBAL_SHUTTER_START;
    codes[6] = `ISC_TP_EXP_CTRL;
  end

  always #10 pclk = ~pclk;

  isc_config_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measured_black_level(meas), .adc_black_level(adc),
    .black_level_correction(corr), .black_offset_trim(trim), .pipeline_mode(pipe),
    .frame_start(ev[4]), .row_done(ev[3]), .dummy_row_active(dummy), .line_start(ev[2]),
    .pix_valid(ev[1]), .pix_color(col), .shutter_request(ev[0]), .shutter_start(sh_go),
    .shutter_active(sh_on), .pll1_clkout_enable(clk_en), .pll1_lock(src[0]),
    .pll2_lock(src[1]), .pixel_clock(src[2]), .frame_irq_request(src[3]),
    .exposure_irq_request(src[4]), .global_shutter_start(src[5]),
    .exposure_control(src[6]), .digital_test_pin(tpin));

  isc_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ------------------------------
  // Helpers
  // ------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task rd(input [6:0] idx, input [8:0] exp);
    begin
      host_u.xfer({23'h0, idx, 2'h0}, 1'b0, 8'h00, r);
      chk(r, exp);
    end
  endtask

  task wr(input [6:0] idx, input [7:0] d);
    begin
      host_u.xfer({23'h0, idx, 2'h0}, 1'b1, d, r);
      chk(r[8], 1'b0);
      // Outputs that copy a field are one edge behind it
      @(posedge pclk);
    end
  endtask

  // Bits: frame_start, row_done, line_start, pix_valid, shutter_request
  task pulse(input [4:0] m);
    begin
      ev <= m;
      @(posedge pclk);
      ev <= 5'h00;
      @(posedge pclk);
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares = miscompares + 1;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 12; i = i + 1)
      rd(ri[i], 9'h000);
    wr(`ISC_IDX_STATUS, 8'hff);
    rd(`ISC_IDX_STATUS, 9'h008);
    rd(7'h30, 9'h100);
    host_u.xfer(32'ha9, 1'b0, 8'h00, r);
    chk(r, 9'h100);
    chk(adc, meas);
    $display("test reset and map done");
    for (i = 0; i < 3; i = i + 1) begin
      wr(`ISC_IDX_OFFS_LO, host_u.gains[i][7:0]);
      wr(`ISC_IDX_OFFS_HI, host_u.gains[i][15:8]);
      chk(trim, host_u.gains[i]);
    end
    wr(`ISC_IDX_BLVL_LO, 8'hbc);
    wr(`ISC_IDX_BLVL_HI, 8'hff);
    rd(`ISC_IDX_BLVL_HI, 9'h03f);
    wr(`ISC_IDX_BYPASS, 8'h01);
    chk({corr, adc}, {1'b0, 14'h3fbc});
    rd(`ISC_IDX_STATUS, 9'h000);
    wr(`ISC_IDX_BYPASS, 8'h00);
    wr(`ISC_IDX_CLKGATE, 8'h01);
    chk(clk_en, 1'b0);
    wr(`ISC_IDX_CLKGATE, 8'h00);
    chk(clk_en, 1'b1);
    $display("test black level and clock gate done");
    for (i = 0; i < 7; i = i + 1) begin
      wr(`ISC_IDX_TPSEL, {3'h0, codes[i]});
      src <= 7'h01 << i;
      repeat (8) @(posedge pclk);
      chk(tpin, 1'b1);
      src <= ~(7'h01 << i);
      repeat (8) @(posedge pclk);
      chk(tpin, 1'b0);
    end
    wr(`ISC_IDX_TPSEL, 8'h00);
    src <= 7'h7f;
    repeat (8) @(posedge pclk);
    chk(tpin, 1'b0);
    $display("test pin select done");
    // Start is launched the delay's count of edges after the request, seen one read later
    wr(`ISC_IDX_DELAY_LO, 8'h03);
    wr(`ISC_IDX_TGLEN_LO, 8'h02);
    pulse(5'h01);
    n = 1;
    while (!sh_go && n < 40) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk(n, 3 + 1);
    n = 0;
    while (sh_on && n < 40) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk(n, 2 + 1);
    $display("test shutter done");
    wr(`ISC_IDX_DUMMY, 8'h02);
    pipe <= 1'b1;
    pulse(5'h10);
    chk(dummy, 1'b1);
    pulse(5'h08);
    chk(dummy, 1'b1);
    pulse(5'h08);
    chk(dummy, 1'b0);
    pipe <= 1'b0;
    pulse(5'h10);
    chk({dummy, col}, {1'b0, `ISC_COL_BLUE});
    pulse(5'h02);
    chk(col, `ISC_COL_GREEN_B);
    pulse(5'h04);
    chk(col, `ISC_COL_GREEN_R);
    pulse(5'h02);
    chk(col, `ISC_COL_RED);
    pulse(5'h10);
    chk(col, `ISC_COL_BLUE);
    $display("test dummy rows and colour order done");
    end_of_test;
  end
endmodule
